// ### rtl/ohf_pkg.sv
package ohf_pkg;
  // apb register map, byte addresses
  localparam int APB_AW = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h010;
  // control register
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  // status register fields
  localparam int STS_STATE_LSB = 0;
  localparam int STS_CNT_LSB = 4;
  localparam int STS_HS_BIT = 8;
  localparam int STS_LS_BIT = 9;
  localparam int STS_PD_BIT = 10;
  localparam int STS_UVOK_BIT = 11;
  localparam int STS_RAMP_BIT = 12;
  // interrupt bits, same layout in stat, clr and en
  localparam int IRQ_W = 4;
  localparam int IRQ_OC_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_RESTART_BIT = 2;
  localparam int IRQ_LOCK_BIT = 3;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  // fault counter
  localparam int CNT_W = 3;
  localparam logic [2:0] FAULT_LIMIT = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int REACT_NS = 20;
  localparam int REACT_RAW = (REACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REACT_CYC = (REACT_RAW < 1) ? 1 : REACT_RAW;
  localparam int BLANK_TIMEOUT_NS = 400;
  localparam int BLANK_RAW = BLANK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (BLANK_RAW < 1) ? 1 : BLANK_RAW;
  localparam int SS_SW_CYCLES = 8;
  // controller states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_START,
    ST_RUN,
    ST_FAULT
  } ohf_state_type;
endpackage

// ### rtl/ohf_sync2.sv
`timescale 1ns/1ns
module ohf_sync2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // two flops per bit; the first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic stab_q;
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        meta_q <= 1'b0;
        stab_q <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        stab_q <= meta_q;
      end
    end
    assign sync_out[i] = stab_q;
  end
endmodule // ohf_sync2

// ### rtl/ohf_fault_counter.sv
`timescale 1ns/1ns
module ohf_fault_counter
  import ohf_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // count controls, clear has priority
  input wire logic cnt_clr,
  input wire logic cnt_inc,
  input wire logic cnt_dec,
  // current count
  output logic [WIDTH-1:0] cnt_q
);
  logic [WIDTH-1:0] cnt_d; // next count
  logic at_max; // saturated high
  logic at_zero; // saturated low
  assign at_max = (cnt_q == {WIDTH{1'b1}});
  assign at_zero = (cnt_q == '0);
  // saturate both ways so a long clean run cannot wrap to seven
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_clr) begin
      cnt_d = '0;
    end else if (cnt_inc && !at_max) begin
      cnt_d = cnt_q + WIDTH'(1);
    end else if (cnt_dec && !cnt_inc && !at_zero) begin
      cnt_d = cnt_q - WIDTH'(1);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // ohf_fault_counter

// ### rtl/ohf_hiccup_top.sv
`timescale 1ns/1ns
module ohf_hiccup_top
  import ohf_pkg::*;
#(
  parameter int SS_CYCLES = SS_SW_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // analog comparator and timing inputs, asynchronous
  input wire logic supply_at_start,
  input wire logic supply_below_stop,
  input wire logic cycle_clock,
  input wire logic pwm_request,
  input wire logic overcurrent_cmp,
  input wire logic switch_node_near_supply,
  input wire logic ramp_amplitude_ok,
  input wire logic soft_start_done,
  // power stage
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic current_limit_sense_node_pulldown,
  output logic hiccup_fault,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);
  // synchronised inputs
  logic [7:0] sync_v;
  logic at_start_s, below_s, cyc_s, pwm_s, oc_s, sw_s, ramp_s, ss_s;
  ohf_sync2 #(.WIDTH(8)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({soft_start_done, ramp_amplitude_ok, switch_node_near_supply,
               overcurrent_cmp, pwm_request, cycle_clock, supply_below_stop,
               supply_at_start}),
    .sync_out(sync_v)
  );
  assign {ss_s, ramp_s, sw_s, oc_s, pwm_s, cyc_s, below_s, at_start_s} = sync_v;

  // state and flops
  ohf_state_type st_q, st_d; // controller state
  logic cyc_d1_q; // cycle clock delayed for edge detect
  logic uvok_q; // lockout released
  logic ctrl_en_q; // software enable
  logic hs_q, ls_q, pd_q; // drive and pulldown flops
  logic arm_q; // one clock lead between pulldown and turn-on
  logic term_q; // pulse cut by overcurrent this cycle
  logic oc_cyc_q; // an overcurrent happened this cycle
  logic first_q; // first high pulse seen since soft start
  logic ramp_seen_q, ramp_good_q; // ramp amplitude tracking
  logic [7:0] blank_q; // blanking timeout counter
  logic [3:0] react_q; // reaction delay counter
  logic [7:0] ss_div_q; // switching cycles within one soft-start cycle
  logic fault_q; // registered fault flag
  logic [CNT_W-1:0] cnt_q; // fault counter value

  // combinational nets
  logic cyc_pulse, run_ok, counting, counting_d, oc_live;
  logic react_done, blank_exp, release_pd, ss_tick;
  logic cnt_max, cnt_zero, cnt_inc, cnt_dec, cnt_clr;
  logic hs_d, ls_d, pd_d, hs_allow;

  assign cyc_pulse = cyc_s & ~cyc_d1_q;
  assign run_ok = uvok_q & ctrl_en_q;
  assign counting = (st_q == ST_START) | (st_q == ST_RUN);
  assign counting_d = (st_d == ST_START) | (st_d == ST_RUN);
  assign cnt_max = (cnt_q == FAULT_LIMIT);
  assign cnt_zero = (cnt_q == '0);

  // lockout hysteresis: comparators give start and stop levels
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      uvok_q <= 1'b0;
    end else if (below_s) begin
      uvok_q <= 1'b0;
    end else if (at_start_s) begin
      uvok_q <= 1'b1;
    end
  end

  // controller state sequencing
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        if (run_ok) st_d = ST_START;
      end
      ST_START: begin
        if (cnt_max) st_d = ST_FAULT;
        else if (first_q && ss_s) st_d = ST_RUN;
      end
      ST_RUN: begin
        if (cnt_max) st_d = ST_FAULT;
      end
      ST_FAULT: begin
        if (cnt_zero) st_d = ST_START;
      end
      default: st_d = ST_OFF;
    endcase
    if (!run_ok) st_d = ST_OFF;
  end

  // per-cycle counting; fault soft-start cycles tick the counter down
  assign ss_tick = cyc_pulse & (st_q == ST_FAULT) &
                   (ss_div_q == 8'(SS_CYCLES - 1));
  assign cnt_inc = cyc_pulse & counting & oc_cyc_q;
  assign cnt_dec = (cyc_pulse & counting & ~oc_cyc_q) | ss_tick;
  assign cnt_clr = (st_q == ST_OFF);
  ohf_fault_counter #(.WIDTH(CNT_W)) u_cnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cnt_clr(cnt_clr),
    .cnt_inc(cnt_inc),
    .cnt_dec(cnt_dec),
    .cnt_q(cnt_q)
  );

  // blanking: pulldown set at cycle start, released by switch node or timer
  assign react_done = pd_q & sw_s & (react_q == 4'(REACT_CYC - 1));
  assign blank_exp = pd_q & (blank_q == 8'(BLANK_CYC - 1));
  assign release_pd = react_done | blank_exp;
  assign pd_d = (cyc_pulse & counting_d) | (pd_q & ~release_pd & counting_d);
  // comparator is blind while the node is pulled down
  assign oc_live = oc_s & hs_q & ~pd_q;

  // high side: starts one clock after pulldown, cut on overcurrent
  assign hs_allow = counting_d & ramp_good_q & ~term_q & ~oc_live;
  assign hs_d = hs_allow & pwm_s & (hs_q | arm_q) & ~cyc_pulse;

  // low side: soft start waits for the first pulse, run follows cycle
  always_comb begin
    ls_d = 1'b0;
    case (st_d)
      ST_START: ls_d = first_q & ~hs_d;
      ST_RUN: ls_d = ~hs_d & ~cyc_pulse & (ls_q | (hs_q & ~hs_d));
      ST_FAULT: ls_d = 1'b0;
      default: ls_d = 1'b0;
    endcase
  end

  // state and drive flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= ST_OFF;
      cyc_d1_q <= 1'b0;
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      pd_q <= 1'b0;
      arm_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cyc_d1_q <= cyc_s;
      hs_q <= hs_d;
      ls_q <= ls_d;
      pd_q <= pd_d;
      arm_q <= cyc_pulse & counting_d;
      fault_q <= (st_d == ST_FAULT);
    end
  end

  // per-cycle flags; for term_q and oc_cyc_q a set in the clearing cycle wins, first_q clears when counting stops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      term_q <= 1'b0;
      oc_cyc_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      term_q <= oc_live | (term_q & ~cyc_pulse);
      oc_cyc_q <= oc_live | (oc_cyc_q & ~cyc_pulse);
      first_q <= counting_d & (first_q | hs_q);
    end
  end

  // ramp must reach amplitude inside a whole cycle before pulses start
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ramp_seen_q <= 1'b0;
      ramp_good_q <= 1'b0;
    end else if (st_q == ST_OFF) begin
      ramp_seen_q <= 1'b0;
      ramp_good_q <= 1'b0;
    end else if (cyc_pulse) begin
      ramp_seen_q <= ramp_s;
      ramp_good_q <= ramp_seen_q | ramp_s;
    end else begin
      ramp_seen_q <= ramp_seen_q | ramp_s;
    end
  end

  // blanking and reaction counters
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blank_q <= 8'h00;
      react_q <= 4'h0;
    end else begin
      blank_q <= (pd_q & ~release_pd) ? blank_q + 8'h01 : 8'h00;
      react_q <= (pd_q & sw_s & ~release_pd) ? react_q + 4'h1 : 4'h0;
    end
  end

  // soft-start cycle divider, only runs while in fault
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ss_div_q <= 8'h00;
    end else if (st_q != ST_FAULT) begin
      ss_div_q <= 8'h00;
    end else if (ss_tick) begin
      ss_div_q <= 8'h00;
    end else if (cyc_pulse) begin
      ss_div_q <= ss_div_q + 8'h01;
    end
  end

  // apb slave: one wait state, writes land when pready is sampled high
  function automatic logic hit(input logic [APB_AW-1:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction
  logic acc, wr_fire, mapped;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q, ev, clr_mask, irq_stat_d;
  logic [31:0] status_w, rd_w;
  assign acc = psel & penable & ~pready;
  assign wr_fire = psel & penable & pwrite & pready & pstrb[0];
  assign mapped = hit(paddr, ADDR_CTRL) | hit(paddr, ADDR_STATUS) |
                  hit(paddr, ADDR_IRQ_STAT) | hit(paddr, ADDR_IRQ_CLR) |
                  hit(paddr, ADDR_IRQ_EN);
  assign status_w = (32'(st_q) << STS_STATE_LSB) | (32'(cnt_q) << STS_CNT_LSB) |
                    (32'(hs_q) << STS_HS_BIT) | (32'(ls_q) << STS_LS_BIT) |
                    (32'(pd_q) << STS_PD_BIT) | (32'(uvok_q) << STS_UVOK_BIT) |
                    (32'(ramp_good_q) << STS_RAMP_BIT);
  assign rd_w = hit(paddr, ADDR_CTRL) ? 32'(ctrl_en_q) :
                hit(paddr, ADDR_STATUS) ? status_w :
                hit(paddr, ADDR_IRQ_STAT) ? 32'(irq_stat_q) :
                hit(paddr, ADDR_IRQ_EN) ? 32'(irq_en_q) : 32'h0000_0000;

  // events: trip, fault entry, restart, lockout drop
  assign ev[IRQ_OC_BIT] = oc_live;
  assign ev[IRQ_FAULT_BIT] = (st_d == ST_FAULT) & (st_q != ST_FAULT);
  assign ev[IRQ_RESTART_BIT] = (st_q == ST_FAULT) & (st_d == ST_START);
  assign ev[IRQ_LOCK_BIT] = (st_q != ST_OFF) & (st_d == ST_OFF);
  assign clr_mask = (wr_fire & hit(paddr, ADDR_IRQ_CLR)) ? pwdata[IRQ_W-1:0] : '0;
  // new events win over a clear in the same cycle
  assign irq_stat_d = ev | (irq_stat_q & ~clr_mask);

  // register file and bus answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_en_q <= CTRL_EN_RESET;
      irq_en_q <= IRQ_EN_RESET;
      irq_stat_q <= '0;
      irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      if (wr_fire && hit(paddr, ADDR_CTRL)) ctrl_en_q <= pwdata[CTRL_EN_BIT];
      if (wr_fire && hit(paddr, ADDR_IRQ_EN)) irq_en_q <= pwdata[IRQ_W-1:0];
      irq_stat_q <= irq_stat_d;
      irq <= |(irq_stat_d & irq_en_q);
      pready <= acc;
      pslverr <= acc & ~mapped;
      prdata <= (acc && !pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  // outputs straight from flops
  assign high_side_gate_drive = hs_q;
  assign low_side_gate_drive = ls_q;
  assign current_limit_sense_node_pulldown = pd_q;
  assign hiccup_fault = fault_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_oc_hit;
    hs_q && oc_s && !pd_q;
  endsequence
  sequence s_cycle_begin;
    cyc_pulse && counting_d;
  endsequence
  a_oc_ends_pulse: assert property (s_oc_hit |=> !hs_q[*2])
    else $error("high side not cut on overcurrent");
  a_term_holds_off: assert property (term_q && !cyc_pulse |=> !hs_q)
    else $error("high side back on before next cycle");
  a_pd_leads_on: assert property ($rose(hs_q) |-> $past(pd_q) && $past(arm_q))
    else $error("turn-on without pulldown lead");
  a_pd_at_cycle: assert property (s_cycle_begin |=> pd_q)
    else $error("pulldown not set at cycle start");
  a_blank_timeout: assert property (pd_q && blank_q == 8'(BLANK_CYC - 1) |=> !pd_q)
    else $error("blanking exceeded timeout");
  a_react_release: assert property (pd_q && sw_s && !cyc_pulse && react_q == 4'(REACT_CYC - 1)
                                    |=> !pd_q)
    else $error("pulldown not released after reaction delay");
  a_oc_blanked: assert property (hs_q && pd_q && pwm_s && !cyc_pulse && !term_q &&
                                 st_d == st_q && counting |=> hs_q)
    else $error("overcurrent acted during blanking");
  a_count_up: assert property (cnt_inc && !cnt_max && !cnt_clr
                               |=> cnt_q == $past(cnt_q) + 3'h1)
    else $error("fault counter missed increment");
  a_fault_entry: assert property (cnt_max && counting && run_ok |=> st_q == ST_FAULT)
    else $error("no fault at count seven");
  a_fault_idle: assert property (st_q == ST_FAULT |-> !hs_q && !ls_q)
    else $error("drive active during fault");
  a_restart: assert property (st_q == ST_FAULT && cnt_zero && run_ok
                              |=> st_q == ST_START)
    else $error("no restart at zero count");
  a_ramp_gate: assert property (!ramp_good_q |=> !hs_q)
    else $error("pulse without ramp amplitude");
  a_ls_soft: assert property (st_q == ST_START && !first_q |-> !ls_q)
    else $error("low side on before first pulse");
  a_ls_cycle: assert property (cyc_pulse && st_d == ST_RUN |=> !ls_q)
    else $error("low side not off at cycle start");
  a_lock_clear: assert property (st_q == ST_OFF |=> cnt_zero)
    else $error("counter not cleared in lockout");
endmodule // ohf_hiccup_top

// ### verif/ohf_power_stage.sv
`timescale 1ns/1ns
// behavioural power stage; the switch node follows the high side one clock late
module ohf_power_stage (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // gate drives from the controller
  input wire logic hs_on,
  input wire logic ls_on,
  // bench commands: shorted load, switch node that never rises
  input wire logic short_mode,
  input wire logic sw_stuck,
  // sensed levels back to the controller
  output logic sw_near,
  output logic oc_trip,
  output logic overlap_seen
);
  // a real short trips at once, inside blanking too, so blanking is exercised
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sw_near <= 1'b0;
      oc_trip <= 1'b0;
      overlap_seen <= 1'b0;
    end else begin
      sw_near <= hs_on & ~sw_stuck;
      oc_trip <= hs_on & short_mode;
      overlap_seen <= overlap_seen | (hs_on & ls_on);
    end
  end
endmodule // ohf_power_stage

// ### verif/overcurrent_hiccup_fault_logic_bench.sv
`timescale 1ns/1ns
module overcurrent_hiccup_fault_logic_bench;
  import ohf_pkg::*;
  localparam int PER = 40; // clocks per switching cycle
  localparam int SS = 1; // short soft-start cycle keeps the run brief
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic supply_at_start = 1'b0;
  logic supply_below_stop = 1'b1;
  logic cycle_clock = 1'b0;
  logic pwm_request = 1'b0;
  logic ramp_amplitude_ok = 1'b0;
  logic soft_start_done = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic short_mode = 1'b0;
  logic sw_stuck = 1'b0;
  logic live = 1'b0; // normal switching expected
  logic ls_wait = 1'b1; // low side must wait for the first pulse
  logic hs, ls, pd, hiccup_fault, irq, pready, pslverr, oc, sw_near, overlap_seen;
  // history flops start low so the first edge tests after reset see no unknowns
  logic hs_p = 1'b0, hs_pp = 1'b0, pd_p = 1'b0, hf_p = 1'b0, cc_p = 1'b0;
  logic hs_in_pd = 1'b0, e;
  logic [31:0] prdata, q;
  logic [15:0] lfsr = 16'hF9B6;
  int n_errors = 0;
  int samples_checked = 0;
  int phase = 0;
  int duty = 20;
  int pd_len = 0;
  int n_hs = 0;
  int trips = 0;
  int ss_cnt = 0;
  int n_faults = 0;

  ohf_hiccup_top #(.SS_CYCLES(SS)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .supply_at_start(supply_at_start),
    .supply_below_stop(supply_below_stop), .cycle_clock(cycle_clock),
    .pwm_request(pwm_request), .overcurrent_cmp(oc), .switch_node_near_supply(sw_near),
    .ramp_amplitude_ok(ramp_amplitude_ok), .soft_start_done(soft_start_done),
    .high_side_gate_drive(hs), .low_side_gate_drive(ls),
    .current_limit_sense_node_pulldown(pd), .hiccup_fault(hiccup_fault),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  ohf_power_stage stage_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .hs_on(hs), .ls_on(ls), .short_mode(short_mode),
    .sw_stuck(sw_stuck), .sw_near(sw_near), .oc_trip(oc), .overlap_seen(overlap_seen));

  always #20 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected blanking length: timer bound when the node never rose, else a short reaction
  function automatic logic blank_ok(input int n, input logic timed);
    if (timed) return n >= BLANK_CYC && n <= BLANK_CYC + 1;
    return n >= 2 && n <= REACT_CYC + 5;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                        input string what);
    apb(1'b0, a, 32'h0);
    check(what, q & m, x);
  endtask
  // align to mid-cycle, where blanking is over, then let n cycles pass
  task automatic wait_cyc(input int n);
    while (phase != 20) @(posedge clk_sys);
    repeat (n * PER) @(posedge clk_sys);
  endtask

  // switching-cycle pin and a random duty request each cycle
  always @(posedge clk_sys) begin
    phase <= (phase == PER - 1) ? 0 : phase + 1;
    cycle_clock <= (phase < 4);
    pwm_request <= (phase < duty);
    if (phase == PER - 1) begin
      lfsr <= lfsr_next(lfsr);
      duty <= 20 + lfsr[3:0] % 10;
    end
  end

  // watch the drives at the falling edge, where registered outputs have settled
  always @(negedge clk_sys) begin
    if (rst_n) begin
      hs_p <= hs;
      hs_pp <= hs_p;
      pd_p <= pd;
      hf_p <= hiccup_fault;
      cc_p <= cycle_clock;
      pd_len <= pd ? pd_len + 1 : 0;
      if (hs && !hs_p) begin
        n_hs <= n_hs + 1;
        hs_in_pd <= pd;
        ls_wait <= 1'b0;
        check("pulldown at turn-on", pd, 1'b1);
        check("turn-on near cycle start", phase >= 3 && phase <= 8, 1'b1);
        check("low side at turn-on", ls, 1'b0);
      end
      if (pd_p && !pd) begin
        // fault entry drops the pulldown at once; that cut is not a blanking window
        if (!hiccup_fault) begin
          check("blank length", blank_ok(pd_len, sw_stuck || !hs_in_pd), 1'b1);
        end
        if (hs_in_pd) check("high side across blanking", hs, 1'b1);
        hs_in_pd <= 1'b0;
      end
      if (hs_p && !hs && pwm_request && !hiccup_fault) trips <= trips + 1;
      if (hs_pp && !hs_p && live && !hiccup_fault) check("low side after high", ls, 1'b1);
      if (hiccup_fault && !hf_p) begin
        n_faults <= n_faults + 1;
        check("trips before fault", trips, FAULT_LIMIT);
        trips <= 0;
        ss_cnt <= 0;
      end
      if (hiccup_fault && cycle_clock && !cc_p) ss_cnt <= ss_cnt + 1;
      if (hf_p && !hiccup_fault) begin
        check("soft-start cycles", ss_cnt, FAULT_LIMIT * SS);
        ls_wait <= 1'b1;
        trips <= 0;
      end
      if (hiccup_fault) check("idle in fault", {hs, ls}, 2'b00);
      if (ls_wait) check("low side waits", ls, 1'b0);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(ADDR_CTRL, 32'h1, 32'h1, "ctrl reset");
    rd_chk(ADDR_IRQ_EN, 32'hF, 32'h0, "irq enable reset");
    rd_chk(ADDR_IRQ_CLR, 32'hF, 32'h0, "irq clear reads");
    apb(1'b0, 12'hFFC, 32'h0);
    check("unmapped error", e, 1'b1);
    check("unmapped data", q, 32'h0);
    apb(1'b1, ADDR_IRQ_EN, 32'hF);
    // supply good but ramp too small: pulses refused
    supply_below_stop <= 1'b0;
    supply_at_start <= 1'b1;
    wait_cyc(4);
    check("pulses without ramp", n_hs, 0);
    ramp_amplitude_ok <= 1'b1;
    live <= 1'b1;
    wait_cyc(6);
    check("pulses with ramp", n_hs > 0, 1'b1);
    rd_chk(ADDR_STATUS, 32'h3, 32'h2, "state run");
    // switch node never rises: blanking ends on the timer
    sw_stuck <= 1'b1;
    wait_cyc(3);
    // hard short under long blanking, kept across two hiccups
    // start it with the high side off, so no half pulse is counted by one side only
    while (phase != 36) @(posedge clk_sys);
    short_mode <= 1'b1;
    while (n_faults < 2) @(posedge clk_sys);
    rd_chk(ADDR_IRQ_STAT, 32'h7, 32'h7, "events seen");
    check("irq raised", irq, 1'b1);
    short_mode <= 1'b0;
    sw_stuck <= 1'b0;
    while (hiccup_fault !== 1'b0) @(posedge clk_sys);
    wait_cyc(4);
    rd_chk(ADDR_STATUS, 32'h73, 32'h02, "run with count at floor");
    apb(1'b1, ADDR_IRQ_CLR, 32'hF);
    rd_chk(ADDR_IRQ_STAT, 32'hF, 32'h0, "events cleared");
    check("irq cleared", irq, 1'b0);
    // only the lockout event may interrupt now
    apb(1'b1, ADDR_IRQ_EN, 32'h8);
    short_mode <= 1'b1;
    wait_cyc(3);
    short_mode <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("count raised", q[6:4] != 3'h0, 1'b1);
    check("trip masked", irq, 1'b0);
    live <= 1'b0;
    supply_at_start <= 1'b0;
    supply_below_stop <= 1'b1;
    wait_cyc(1);
    rd_chk(ADDR_STATUS, 32'h373, 32'h0, "off, cleared, idle");
    check("lockout irq", irq, 1'b1);
    check("no overlap", overlap_seen, 1'b0);
    final_report();
  end
endmodule // overcurrent_hiccup_fault_logic_bench
